/* hw/sdram_cmd_pkg.sv */
// Shared constants, types and states of the SDRAM command block
package sdram_cmd_pkg;

  // Clock and timing
  localparam int CLOCK_NS = 100;
  localparam int RETENTION_NS = 64_000_000;
  localparam int ROW_COUNT = 4096;
  localparam int ROW_BITS = 12;
  localparam int ROW_INTERVAL_NS = RETENTION_NS / ROW_COUNT;
  localparam int ROW_INTERVAL_RAW = ROW_INTERVAL_NS / CLOCK_NS;
  localparam int ROW_INTERVAL_CYCLES =
    (ROW_INTERVAL_RAW < 1) ? 1 : ROW_INTERVAL_RAW;
  localparam int SR_TIMER_W = $clog2(ROW_INTERVAL_CYCLES + 1);
  localparam logic [SR_TIMER_W-1:0] SR_TIMER_LAST =
    SR_TIMER_W'(ROW_INTERVAL_CYCLES - 1);
  localparam logic [SR_TIMER_W-1:0] SR_TIMER_ZERO = '0;

  // Power-down exit time, a plain default
  localparam int POWERDOWN_EXIT_NS = 100;
  localparam int PDE_RAW = (POWERDOWN_EXIT_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int POWERDOWN_EXIT_CYCLES = (PDE_RAW < 1) ? 1 : PDE_RAW;
  localparam int PDE_W = 4;
  localparam logic [PDE_W-1:0] PDE_LOAD = PDE_W'(POWERDOWN_EXIT_CYCLES - 1);
  localparam logic [PDE_W-1:0] PDE_ZERO = '0;

  // Data path
  localparam int BYTE_LANES = 4;
  localparam int LATENCY_W = 2;
  localparam logic [BYTE_LANES-1:0] LANES_OFF = '1;
  localparam logic [BYTE_LANES-1:0] LANES_NONE = '0;

  // Command pins as sampled on the rising edge
  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_strobe_n;
    logic clock_gate;
  } cmd_pins_s;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_POWER_DOWN = 2'b01,
    ST_PD_EXIT = 2'b10,
    ST_SELF_REFRESH = 2'b11
  } power_state_e;

endpackage

/* hw/latency_timer.sv */
// Counts the CAS latency after a read burst stop
`timescale 1ns/1ps
module latency_timer #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic en,
  input wire logic start,
  input wire logic [W-1:0] latency,
  output logic done,
  output logic busy
);
  logic [W-1:0] count;
  localparam logic [W-1:0] ONE = W'(1);
  localparam logic [W-1:0] ZERO = '0;

  assign busy = (count != ZERO);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      done <= 1'b0;
    end else if (en) begin
      done <= (count == ONE);
      if (start) begin
        count <= latency;
      end else if (busy) begin
        count <= count - ONE;
      end
    end
  end
endmodule

/* hw/refresh_row.sv */
// Internal refresh row counter with a strobe per refreshed row
`timescale 1ns/1ps
module refresh_row #(
  parameter int ROW_W = 12
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic en,
  input wire logic step,
  output logic strobe,
  output logic [ROW_W-1:0] row
);
  logic [ROW_W-1:0] count;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      row <= '0;
      strobe <= 1'b0;
    end else if (en) begin
      strobe <= step;
      if (step) begin
        row <= count;
        count <= count + ROW_W'(1);
      end
    end
  end
endmodule

/* hw/sdram_cmd_ctrl.sv */
// SDRAM command decode, refresh, clock suspend and power-down control
// Overview of operation
// - Chip selected with all three strobes high does nothing.
// - Selected, row and column strobes high, write strobe low: burst stop.
// - Burst stop leaves bursts with auto precharge running.
// - Read burst ends CAS latency cycles after burst stop.
// - Chip select high disables the decoder; strobes are ignored.
// - Row and column low, write high, gate high: auto refresh.
// - Each auto refresh advances the internal row counter by one.
// - Refresh command with gate low enters self refresh; gate only.
// - Self refresh times and addresses rows internally, without limit.
// - Gate low during a burst masks internal clock, state held.
// - Gate low with banks idle enters power-down, buffers off.
// - Gate high resumes clock; power-down exit waits exit time.
// - Byte mask high during write blocks that byte.
// - Byte mask high during read disables that byte's outputs.
`timescale 1ns/1ps
module sdram_cmd_ctrl #(
  parameter int ROW_W = sdram_cmd_pkg::ROW_BITS,
  parameter int LANES = sdram_cmd_pkg::BYTE_LANES
) (
  // Clock, reset, clock enable
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic ENABLE,
  // Command pins
  input wire logic CHIP_SELECT_N,
  input wire logic ROW_STROBE_N,
  input wire logic COLUMN_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic CLOCK_GATE,
  input wire logic [LANES-1:0] BYTE_MASK,
  // Core status
  input wire logic READ_BURST,
  input wire logic WRITE_BURST,
  input wire logic AUTO_PRECHARGE,
  input wire logic BANKS_IDLE,
  input wire logic [sdram_cmd_pkg::LATENCY_W-1:0] CAS_LATENCY,
  // Burst control
  output logic READ_STOP,
  output logic WRITE_STOP,
  // Refresh
  output logic REFRESH_STROBE,
  output logic [ROW_W-1:0] REFRESH_ROW,
  // Power and clock
  output logic SELF_REFRESH,
  output logic POWER_DOWN,
  output logic CLOCK_RUN,
  output logic BUFFERS_ON,
  // Data lanes
  output logic [LANES-1:0] BYTE_WRITE,
  output logic [LANES-1:0] DQ_OE_N
);
  import sdram_cmd_pkg::*;

  cmd_pins_s pins;
  power_state_e state;
  power_state_e next_state;
  logic gate_prev;
  logic wr_stopped;
  logic [SR_TIMER_W-1:0] sr_timer;
  logic [PDE_W-1:0] pde_count;
  logic rd_done;
  logic rd_wait;
  logic strobe;
  logic [ROW_W-1:0] row;

  assign pins = '{chip_select_n: CHIP_SELECT_N, row_strobe_n: ROW_STROBE_N,
                  column_strobe_n: COLUMN_STROBE_N,
                  write_strobe_n: WRITE_STROBE_N, clock_gate: CLOCK_GATE};

  // Decoder lives only on an unmasked internal clock in normal operation
  wire live = ENABLE && gate_prev && (state == ST_ACTIVE);
  wire selected = live && !pins.chip_select_n;
  wire cmd_nop = selected && pins.row_strobe_n && pins.column_strobe_n
                 && pins.write_strobe_n;
  wire cmd_stop = selected && pins.row_strobe_n && pins.column_strobe_n
                  && !pins.write_strobe_n;
  wire cmd_refresh_any = selected && !pins.row_strobe_n
                         && !pins.column_strobe_n && pins.write_strobe_n;
  wire cmd_auto_ref = cmd_refresh_any && pins.clock_gate;
  wire cmd_self = cmd_refresh_any && !pins.clock_gate;
  wire bursting = READ_BURST || WRITE_BURST;
  wire stop_ok = cmd_stop && !AUTO_PRECHARGE;
  wire stop_rd = stop_ok && READ_BURST && !rd_wait;
  wire stop_wr = stop_ok && WRITE_BURST;
  wire gate_off = live && !pins.clock_gate && !cmd_self;
  wire enter_pd = gate_off && !bursting && BANKS_IDLE;
  wire sr_tick = (state == ST_SELF_REFRESH) && (sr_timer == SR_TIMER_LAST);
  wire ref_step = cmd_auto_ref || sr_tick;
  wire pde_done = (pde_count == PDE_ZERO);
  wire next_run = (next_state == ST_ACTIVE) && pins.clock_gate;
  wire next_bufs = (next_state == ST_ACTIVE)
                   || (next_state == ST_PD_EXIT);
  wire write_ok = live && WRITE_BURST && !stop_wr && !wr_stopped;
  wire [LANES-1:0] next_byte_write =
    write_ok ? ~BYTE_MASK : LANES_NONE;
  wire [LANES-1:0] next_oe_n =
    (live && READ_BURST) ? BYTE_MASK : LANES_OFF;

  always_comb begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (cmd_self) begin
          next_state = ST_SELF_REFRESH;
        end else if (enter_pd) begin
          next_state = ST_POWER_DOWN;
        end
      end
      ST_POWER_DOWN: begin
        if (pins.clock_gate) begin
          next_state = ST_PD_EXIT;
        end
      end
      ST_PD_EXIT: begin
        if (pde_done) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_SELF_REFRESH: begin
        // Exit needs only the gate; every other pin is ignored here
        if (pins.clock_gate) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_ACTIVE;
      gate_prev <= 1'b1;
      SELF_REFRESH <= 1'b0;
      POWER_DOWN <= 1'b0;
      CLOCK_RUN <= 1'b1;
      BUFFERS_ON <= 1'b1;
    end else if (ENABLE) begin
      state <= next_state;
      gate_prev <= pins.clock_gate;
      SELF_REFRESH <= (next_state == ST_SELF_REFRESH);
      POWER_DOWN <= (next_state == ST_POWER_DOWN)
                    || (next_state == ST_PD_EXIT);
      CLOCK_RUN <= next_run;
      BUFFERS_ON <= next_bufs;
    end
  end

  // Self refresh runs off the block clock; a stopped clock stalls it
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sr_timer <= '0;
      pde_count <= '0;
    end else if (ENABLE) begin
      if (state != ST_SELF_REFRESH || sr_tick) begin
        sr_timer <= SR_TIMER_ZERO;
      end else begin
        sr_timer <= sr_timer + SR_TIMER_W'(1);
      end
      if (state == ST_POWER_DOWN) begin
        pde_count <= PDE_LOAD;
      end else if (!pde_done) begin
        pde_count <= pde_count - PDE_W'(1);
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wr_stopped <= 1'b0;
      WRITE_STOP <= 1'b0;
      BYTE_WRITE <= LANES_NONE;
      DQ_OE_N <= LANES_OFF;
    end else if (ENABLE) begin
      // Held through a clock suspend so a stopped write stays stopped
      if (stop_wr) begin
        wr_stopped <= 1'b1;
      end else if (!WRITE_BURST) begin
        wr_stopped <= 1'b0;
      end
      WRITE_STOP <= stop_wr;
      BYTE_WRITE <= next_byte_write;
      DQ_OE_N <= next_oe_n;
    end
  end

  // Read data keeps flowing for the latency; the core drops the burst then
  latency_timer #(.W(LATENCY_W)) read_stop_timer (
    .clock(CLOCK),
    .rstn(RSTN),
    .en(ENABLE && gate_prev),
    .start(stop_rd),
    .latency(CAS_LATENCY),
    .done(rd_done),
    .busy(rd_wait)
  );

  refresh_row #(.ROW_W(ROW_W)) row_counter (
    .clock(CLOCK),
    .rstn(RSTN),
    .en(ENABLE),
    .step(ref_step),
    .strobe(strobe),
    .row(row)
  );

  assign READ_STOP = rd_done;
  assign REFRESH_STROBE = strobe;
  assign REFRESH_ROW = row;

  // Helper for the row stepping check
  logic seen_strobe;
  logic [ROW_W-1:0] last_row;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      seen_strobe <= 1'b0;
      last_row <= '0;
    end else if (ENABLE && strobe) begin
      seen_strobe <= 1'b1;
      last_row <= row;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  sequence read_stop_cl2;
    stop_rd && (CAS_LATENCY == 2'h2) ##1 (ENABLE && gate_prev)[*2];
  endsequence

  sequence read_stop_cl3;
    stop_rd && (CAS_LATENCY == 2'h3) ##1 (ENABLE && gate_prev)[*3];
  endsequence

  nop_quiet_a: assert property (
    cmd_nop |=> !strobe && !SELF_REFRESH && !WRITE_STOP)
    else $error("no-op caused an action");
  write_stop_a: assert property (
    stop_wr |=> WRITE_STOP && BYTE_WRITE == LANES_NONE)
    else $error("write not stopped");
  read_stop_a: assert property (
    read_stop_cl2 |=> READ_STOP)
    else $error("read stop not after latency");
  auto_pre_a: assert property (
    cmd_stop && AUTO_PRECHARGE |=> !WRITE_STOP)
    else $error("burst stop hit auto precharge burst");
  deselect_a: assert property (
    live && CHIP_SELECT_N && CLOCK_GATE
    |=> !strobe && !SELF_REFRESH && !WRITE_STOP)
    else $error("deselect decoded a command");
  auto_ref_a: assert property (
    cmd_auto_ref |=> strobe)
    else $error("auto refresh not performed");
  row_step_a: assert property (
    ENABLE && strobe && seen_strobe |-> row == last_row + ROW_W'(1))
    else $error("row did not step");
  self_ref_a: assert property (
    cmd_self ##1 (ENABLE && !CLOCK_GATE) |=> SELF_REFRESH && !BUFFERS_ON)
    else $error("self refresh lost");
  suspend_a: assert property (
    gate_off && bursting |=> !CLOCK_RUN && !POWER_DOWN)
    else $error("clock not suspended");
  power_down_a: assert property (
    enter_pd |=> POWER_DOWN && !BUFFERS_ON)
    else $error("power-down not entered");
  resume_a: assert property (
    ENABLE && state == ST_POWER_DOWN && CLOCK_GATE |=> BUFFERS_ON)
    else $error("buffers not back on");
  mask_a: assert property (
    live && WRITE_BURST && BYTE_MASK[0] |=> !BYTE_WRITE[0])
    else $error("masked byte written");
  oe_mask_a: assert property (
    live && READ_BURST && BYTE_MASK[0] |=> DQ_OE_N[0])
    else $error("masked byte driven");

  // Further checks: latency three, stopped writes, self refresh, power-down, masked and frozen cycles
  read_stop_three_a: assert property (
    read_stop_cl3 |=> READ_STOP)
    else $error("read stop not after latency three");
  write_hold_a: assert property (
    live && WRITE_BURST && wr_stopped |=> BYTE_WRITE == LANES_NONE)
    else $error("stopped write resumed");
  sr_hold_a: assert property (
    ENABLE && state == ST_SELF_REFRESH && !CLOCK_GATE
    |=> SELF_REFRESH && !BUFFERS_ON)
    else $error("self refresh dropped");
  sr_refresh_a: assert property (
    ENABLE && sr_tick |=> strobe)
    else $error("self refresh skipped a row");
  sr_exit_a: assert property (
    ENABLE && state == ST_SELF_REFRESH && CLOCK_GATE
    |=> !SELF_REFRESH && BUFFERS_ON && CLOCK_RUN)
    else $error("self refresh not left");
  masked_quiet_a: assert property (
    ENABLE && state == ST_ACTIVE && !gate_prev
    |=> !strobe && !WRITE_STOP && BYTE_WRITE == LANES_NONE)
    else $error("masked cycle acted");
  pd_stay_a: assert property (
    ENABLE && state == ST_POWER_DOWN && !CLOCK_GATE
    |=> POWER_DOWN && !BUFFERS_ON)
    else $error("power-down left early");
  pd_exit_a: assert property (
    ENABLE && state == ST_PD_EXIT && pde_done && CLOCK_GATE
    |=> !POWER_DOWN && CLOCK_RUN)
    else $error("power-down exit not finished");
  enable_freeze_a: assert property (
    !ENABLE |=> $stable(state) && $stable(REFRESH_ROW) && $stable(READ_STOP))
    else $error("state moved while disabled");
endmodule

/* dv/mem_ctrl_model.sv */
// Behavioural memory controller that drives the command pins
`timescale 1ns/1ps
module mem_ctrl_model
  import sdram_cmd_pkg::*;
(
  // Clock
  input wire logic CLOCK,
  // Command pins
  output cmd_pins_s PINS
);
  // No-ops cover the longer of row cycle and precharge time, slower grade
  localparam int ROW_CYCLE_NS = 70;
  localparam int PRECHARGE_NS = 20;
  localparam int GAP_NS =
    (ROW_CYCLE_NS > PRECHARGE_NS) ? ROW_CYCLE_NS : PRECHARGE_NS;
  localparam int ROW_CYCLE_NOPS = (GAP_NS + CLOCK_NS - 1) / CLOCK_NS;
  initial begin
    PINS = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  end
  // Command for one cycle, then no-ops holding the gate level
  task automatic drive(input logic [3:0] c, input logic g);
    @(posedge CLOCK);
    PINS <= {c, g};
    repeat (ROW_CYCLE_NOPS) begin
      @(posedge CLOCK);
      PINS <= {4'b0111, g};
    end
    #1;
  endtask
  // Each refresh is its own call; a low gate is held through self refresh
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the SDRAM command block
`timescale 1ns/1ps
module tb_top;
  import sdram_cmd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic en = 1'b1;
  logic rd = 1'b0, wr = 1'b0, ap = 1'b0, idle = 1'b1;
  logic [1:0] cl = 2'h2;
  logic [3:0] mask = 4'h0;
  cmd_pins_s pins;
  logic rstop, wstop, rstb, sref, pdown, crun, bufon;
  logic [11:0] row;
  logic [3:0] bw, oen;
  int fail_count = 0;
  int cmp_count = 0;
  int hits;
  initial begin
    forever #50 clk = ~clk;
  end
  mem_ctrl_model mc (.CLOCK(clk), .PINS(pins));
  sdram_cmd_ctrl dut (.CLOCK(clk), .RSTN(rstn), .ENABLE(en),
    .CHIP_SELECT_N(pins.chip_select_n), .ROW_STROBE_N(pins.row_strobe_n),
    .COLUMN_STROBE_N(pins.column_strobe_n),
    .WRITE_STROBE_N(pins.write_strobe_n), .CLOCK_GATE(pins.clock_gate),
    .BYTE_MASK(mask), .READ_BURST(rd), .WRITE_BURST(wr),
    .AUTO_PRECHARGE(ap), .BANKS_IDLE(idle), .CAS_LATENCY(cl),
    .READ_STOP(rstop), .WRITE_STOP(wstop), .REFRESH_STROBE(rstb),
    .REFRESH_ROW(row), .SELF_REFRESH(sref), .POWER_DOWN(pdown),
    .CLOCK_RUN(crun), .BUFFERS_ON(bufon), .BYTE_WRITE(bw),
    .DQ_OE_N(oen));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_refresh();
    for (int i = 0; i < 3; i++) begin
      mc.drive(4'b0001, 1'b1);
      check(rstb, 1'b1);
      check(row, 12'(i));
      mc.drive(4'b1001, 1'b1);
      check(rstb, 1'b0);
      mc.drive(4'b0111, 1'b1);
      check(rstb, 1'b0);
    end
    $display("test refresh done");
  endtask
  task automatic t_hold();
    @(posedge clk);
    en <= 1'b0;
    mc.drive(4'b0001, 1'b1);
    check(rstb, 1'b0);
    @(posedge clk);
    en <= 1'b1;
    mc.drive(4'b0001, 1'b1);
    check({rstb, row}, {1'b1, 12'h003});
    $display("test hold done");
  endtask
  task automatic t_write();
    @(posedge clk);
    wr <= 1'b1;
    mask <= 4'h5;
    @(posedge clk);
    #1;
    check(bw, 4'hA);
    mc.drive(4'b0110, 1'b1);
    check(wstop, 1'b1);
    check(bw, 4'h0);
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    wr <= 1'b1;
    ap <= 1'b1;
    mc.drive(4'b0110, 1'b1);
    check(wstop, 1'b0);
    check(bw, 4'hA);
    @(posedge clk);
    wr <= 1'b0;
    ap <= 1'b0;
    $display("test write done");
  endtask
  task automatic t_read(input logic [1:0] lat);
    @(posedge clk);
    rd <= 1'b1;
    mask <= 4'h1;
    cl <= lat;
    @(posedge clk);
    #1;
    check(oen, 4'h1);
    mc.drive(4'b0110, 1'b1);
    check(rstop, 1'b0);
    repeat (lat) @(posedge clk);
    #1;
    check(rstop, 1'b1);
    @(posedge clk);
    rd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(oen, 4'hF);
    $display("test read done");
  endtask
  task automatic t_power();
    mc.drive(4'b0111, 1'b0);
    check({pdown, bufon, crun}, 3'b100);
    mc.drive(4'b1111, 1'b1);
    check({pdown, bufon}, 2'b11);
    @(posedge clk);
    #1;
    check({pdown, crun}, 2'b01);
    @(posedge clk);
    rd <= 1'b1;
    idle <= 1'b0;
    mc.drive(4'b0111, 1'b0);
    check({pdown, crun}, 2'b00);
    mc.drive(4'b0001, 1'b1);
    check({crun, rstb}, 2'b10);
    @(posedge clk);
    rd <= 1'b0;
    idle <= 1'b1;
    $display("test power done");
  endtask
  task automatic t_self();
    hits = 0;
    mc.drive(4'b0001, 1'b0);
    check({sref, bufon, crun}, 3'b100);
    for (int i = 0; i < 330; i++) begin
      @(posedge clk);
      #1;
      if (rstb === 1'b1) hits++;
    end
    check(16'(hits), 16'h2);
    mc.drive(4'b1111, 1'b1);
    check({sref, bufon, crun}, 3'b011);
    $display("test self refresh done");
  endtask
  initial begin
    #310000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_refresh();
    t_hold();
    t_write();
    t_read(2'h2);
    t_read(2'h3);
    t_power();
    t_self();
    tally_and_finish();
  end
endmodule
